// File: sar_seq_pkg.sv
// Shared constants and types for the SAR conversion sequencer
package sar_seq_pkg;
	localparam int RES_BITS = 18;                              // Result width
	localparam int DIV_RATIO = 2;                              // Clock cycles per conversion-clock tick
	localparam int ACQ_TICKS = 4;                              // Minimum acquisition length in ticks
	localparam logic [RES_BITS-1:0] CODE_MAX = 18'h1FFFF;      // Most positive code
	localparam logic [RES_BITS-1:0] CODE_MIN = 18'h20000;      // Most negative code
	localparam logic [RES_BITS-1:0] CODE_ZERO = 18'h00000;     // Reset result
	localparam logic [RES_BITS-1:0] MSB_ONLY = 18'h20000;      // First trial bit

	// Switch drive bundle towards the analog core
	typedef struct packed {
		logic pos_array_ground_switch;                         // Closed while acquiring
		logic neg_array_ground_switch;                         // Closed while acquiring
		logic arrays_on_inputs;                                // Arrays track the inputs
	} switch_ctl_t;

	// Sequencer phases
	typedef enum logic [2:0] {
		ST_ACQ,
		ST_OPEN_SW,
		ST_TO_GND,
		ST_TRIAL,
		ST_DONE
	} seq_state_t;
endpackage : sar_seq_pkg

// File: conv_clock_div.sv
// Divider producing the internal conversion-clock enable
`timescale 1ns/100ps
`default_nettype none
module conv_clock_div
	import sar_seq_pkg::*;
#(
	parameter int RATIO = DIV_RATIO
) (
	input  wire logic clk,      // System clock
	input  wire logic reset,    // Synchronous reset, high
	output logic      tick      // One-cycle enable pulse
);
	localparam int CW = (RATIO > 1) ? $clog2(RATIO) : 1;
	logic [CW-1:0] cnt_q;

	// Elaboration check on the divide ratio
	if (RATIO < 1) begin : g_bad_ratio
		$error("RATIO must be at least 1");
	end

	// Free-running counter, independent of any serial clock
	always_ff @(posedge clk) begin
		if (reset || cnt_q == CW'(RATIO - 1)) cnt_q <= '0;
		else cnt_q <= cnt_q + 1'b1;
	end

	assign tick = (cnt_q == CW'(RATIO - 1)) && !reset;
endmodule : conv_clock_div
`default_nettype wire

// File: sar_conversion_sequencer.sv
// SAR conversion sequencer: trigger, switch sequence, bit trials, result
// Notes on behaviour
// - Trigger rising edge after acquisition starts conversion
// - Open ground switches, then arrays to ground
// - Eighteen binary-weighted elements give 18-bit result
// - Trial bits MSB first, halving to LSB
// - On finish: acquire, output code, completion pulse
// - Internal conversion clock times the sequence
// - Result belongs to the same conversion
// - Two's complement output code
// - Overrange clamps to most positive code
// - Underrange clamps to most negative code
// - Started conversion ignores later trigger changes
`timescale 1ns/100ps
`default_nettype none
module sar_conversion_sequencer
	import sar_seq_pkg::*;
#(
	parameter int WIDTH = RES_BITS,
	parameter int ACQ_MIN = ACQ_TICKS
) (
	input  wire logic             clk,                // 10 MHz system clock
	input  wire logic             reset,              // Synchronous reset, high
	input  wire logic             conversion_trigger, // Convert trigger
	input  wire logic             comp_high,          // Comparator: trial too low, keep bit
	input  wire logic             over_range,         // Analog core flags input above range
	input  wire logic             under_range,        // Analog core flags input below range
	output switch_ctl_t           sw_ctl,             // Switch drive
	output logic [WIDTH-1:0]      trial_code,         // Array switch pattern under test
	output logic                  busy,               // High while converting
	output logic                  done_pulse,         // One cycle at completion
	output logic [WIDTH-1:0]      result              // Registered output code
);
	localparam int BW = $clog2(WIDTH + 1);
	localparam int AW = $clog2(ACQ_MIN + 1);

	// Elaboration checks on parameters the logic cannot serve
	if (WIDTH != RES_BITS) begin : g_bad_width
		$error("WIDTH must equal RES_BITS");
	end
	if (ACQ_MIN < 1) begin : g_bad_acq
		$error("ACQ_MIN must be at least 1");
	end

	seq_state_t       state_q, state_d;
	logic             trig_q;
	logic [WIDTH-1:0] sar_q, sar_d;
	logic [WIDTH-1:0] bit_q, bit_d;
	logic [AW-1:0]    acq_q;
	logic [WIDTH-1:0] result_q, result_d;
	logic             done_q;
	logic [BW-1:0]    trials_q;
	logic             tick;

	// Internal conversion clock enable
	conv_clock_div #(.RATIO(DIV_RATIO)) u_div (
		.clk   (clk),
		.reset (reset),
		.tick  (tick)
	);

	// Decode of trigger edge and acquisition status
	wire trig_rise = conversion_trigger && !trig_q;
	wire acq_ready = (acq_q == AW'(ACQ_MIN));
	wire start     = (state_q == ST_ACQ) && trig_rise && acq_ready;
	wire last_bit  = bit_q[0];
	wire [WIDTH-1:0] kept = comp_high ? sar_q : (sar_q & ~bit_q);

	// Final code in two's complement with range clamps (sign bit inverted from offset binary)
	wire [WIDTH-1:0] twos = {~kept[WIDTH-1], kept[WIDTH-2:0]};
	wire [WIDTH-1:0] final_code = over_range  ? CODE_MAX :
	                              under_range ? CODE_MIN :
	                              twos;

	// Next-state logic
	always_comb begin
		state_d  = state_q;
		sar_d    = sar_q;
		bit_d    = bit_q;
		result_d = result_q;
		case (state_q)
			ST_ACQ: begin
				if (start) state_d = ST_OPEN_SW;
			end
			ST_OPEN_SW: begin
				if (tick) state_d = ST_TO_GND;
			end
			ST_TO_GND: begin
				if (tick) begin
					state_d = ST_TRIAL;
					sar_d   = MSB_ONLY;
					bit_d   = MSB_ONLY;
				end
			end
			ST_TRIAL: begin
				if (tick) begin
					bit_d = bit_q >> 1;
					sar_d = kept | (bit_q >> 1);
					if (last_bit) begin
						state_d = ST_DONE;
						sar_d   = kept;
					end
				end
			end
			ST_DONE: begin
				state_d  = ST_ACQ;
				result_d = final_code;
			end
			default: state_d = ST_ACQ;
		endcase
	end

	// State registers; trigger ignored outside acquisition
	always_ff @(posedge clk) begin
		if (reset) begin
			state_q  <= ST_ACQ;
			trig_q   <= 1'b1;
			sar_q    <= '0;
			bit_q    <= '0;
			result_q <= CODE_ZERO;
			done_q   <= 1'b0;
		end else begin
			state_q  <= state_d;
			trig_q   <= conversion_trigger;
			sar_q    <= sar_d;
			bit_q    <= bit_d;
			result_q <= result_d;
			done_q   <= (state_q == ST_DONE);
		end
	end

	// Acquisition timer, counts conversion-clock ticks spent acquiring
	always_ff @(posedge clk) begin
		if (reset || state_q != ST_ACQ) acq_q <= '0;
		else if (tick && !acq_ready) acq_q <= acq_q + 1'b1;
	end

	// Trial counter used only for checking
	always_ff @(posedge clk) begin
		if (reset || state_q == ST_TO_GND) trials_q <= '0;
		else if (state_q == ST_TRIAL && tick) trials_q <= trials_q + 1'b1;
	end

	// Switch drive: ground switches open first, arrays leave the inputs one tick later
	wire grounds_closed = (state_q == ST_ACQ) || (state_q == ST_DONE);
	wire on_inputs      = grounds_closed || (state_q == ST_OPEN_SW);
	assign sw_ctl = '{
		pos_array_ground_switch: grounds_closed,
		neg_array_ground_switch: grounds_closed,
		arrays_on_inputs:        on_inputs
	};

	// Data and status outputs
	assign trial_code = sar_q;
	assign busy       = (state_q != ST_ACQ);
	assign done_pulse = done_q;
	assign result     = result_q;

	// Step sequences used by the checks
	sequence open_then_gnd_s;
		(state_q == ST_OPEN_SW && !sw_ctl.pos_array_ground_switch && sw_ctl.arrays_on_inputs);
	endsequence
	sequence early_edge_s;
		(state_q == ST_ACQ && trig_rise && !acq_ready);
	endsequence
	sequence last_trial_s;
		(state_q == ST_TRIAL && tick && last_bit);
	endsequence

	// Checks on start and switch ordering
	start_conv_a: assert property (@(posedge clk) disable iff (reset)
		start |=> open_then_gnd_s)
		else $error("start did not open switches");
	early_refuse_a: assert property (@(posedge clk) disable iff (reset)
		early_edge_s |=> !busy)
		else $error("trigger taken before acquisition ended");
	acq_switches_a: assert property (@(posedge clk) disable iff (reset)
		(state_q == ST_ACQ) |-> sw_ctl.pos_array_ground_switch &&
			sw_ctl.neg_array_ground_switch && sw_ctl.arrays_on_inputs)
		else $error("switches not in acquisition setting");
	switch_order_a: assert property (@(posedge clk) disable iff (reset)
		(state_q == ST_TO_GND) |-> !sw_ctl.arrays_on_inputs && !sw_ctl.neg_array_ground_switch)
		else $error("arrays not grounded after switches open");

	// Checks on the bit trials
	trial_count_a: assert property (@(posedge clk) disable iff (reset)
		(state_q == ST_DONE) |-> trials_q == BW'(WIDTH))
		else $error("wrong trial count");
	msb_first_a: assert property (@(posedge clk) disable iff (reset)
		(state_q == ST_TO_GND && tick) |=> bit_q == MSB_ONLY)
		else $error("first trial not MSB");
	bit_halves_a: assert property (@(posedge clk) disable iff (reset)
		(state_q == ST_TRIAL && tick && !last_bit) |=> bit_q == ($past(bit_q) >> 1))
		else $error("trial step did not halve");
	lsb_last_a: assert property (@(posedge clk) disable iff (reset)
		last_trial_s |=> state_q == ST_DONE)
		else $error("trials did not end after the LSB");
	tick_paced_a: assert property (@(posedge clk) disable iff (reset)
		(state_q == ST_TRIAL && !tick) |=> $stable(bit_q) && $stable(sar_q))
		else $error("trial moved without a conversion tick");

	// Checks on completion and the output code
	done_return_a: assert property (@(posedge clk) disable iff (reset)
		(state_q == ST_DONE) |=> state_q == ST_ACQ && done_pulse && !busy)
		else $error("completion not signalled");
	done_single_a: assert property (@(posedge clk) disable iff (reset)
		done_pulse |=> !done_pulse)
		else $error("completion pulse longer than one cycle");
	twos_code_a: assert property (@(posedge clk) disable iff (reset)
		(state_q == ST_DONE && !over_range && !under_range) |=>
			result == ($past(sar_q) ^ MSB_ONLY))
		else $error("output code not two's complement");
	over_clamp_a: assert property (@(posedge clk) disable iff (reset)
		(state_q == ST_DONE && over_range) |=> result == CODE_MAX)
		else $error("no overrange clamp");
	under_clamp_a: assert property (@(posedge clk) disable iff (reset)
		(state_q == ST_DONE && under_range && !over_range) |=> result == CODE_MIN)
		else $error("no underrange clamp");
	run_through_a: assert property (@(posedge clk) disable iff (reset)
		(busy && state_q != ST_DONE) |=> busy)
		else $error("conversion aborted");
	result_hold_a: assert property (@(posedge clk) disable iff (reset)
		!done_pulse |-> $stable(result))
		else $error("result changed between conversions");
endmodule : sar_conversion_sequencer
`default_nettype wire

// File: sar_analog_model.sv
// Behavioural analog core: comparator answer for a held input code
`timescale 1ns/100ps
`default_nettype none
module sar_analog_model
	import sar_seq_pkg::*;
(
	input  wire logic [RES_BITS-1:0] trial_code, // Pattern under test
	input  wire logic [RES_BITS-1:0] target,     // Held input as signed code
	output logic                     comp_high   // Keep current trial bit
);
	// Keep the bit while the offset-binary trial does not pass the input
	assign comp_high = trial_code <= (target ^ MSB_ONLY);
endmodule : sar_analog_model
`default_nettype wire

// File: sar_conversion_sequencer_test.sv
// Self-checking bench for the SAR conversion sequencer
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin err_count++; \
	$display("ERROR %s expected %h seen %h", nm, e, g); end end
module sar_conversion_sequencer_test
	import sar_seq_pkg::*;
();
	logic                clk, reset, trig, comp_high, over_range, under_range, busy, done_pulse;
	switch_ctl_t         sw_ctl;
	logic [RES_BITS-1:0] trial_code, result, target, exp_q, lfsr_q;
	int                  err_count, num_checks, cycles;
	logic [RES_BITS-1:0] corner [8] = '{18'h00000, 18'h00001, 18'h3FFFF, 18'h1FFFF,
		18'h20000, 18'h20001, 18'h00005, 18'h3FFF0};

	sar_conversion_sequencer u_sar_conversion_sequencer (.clk(clk), .reset(reset),
		.conversion_trigger(trig), .comp_high(comp_high), .over_range(over_range),
		.under_range(under_range), .sw_ctl(sw_ctl), .trial_code(trial_code), .busy(busy),
		.done_pulse(done_pulse), .result(result));
	sar_analog_model u_sar_analog_model (.trial_code(trial_code), .target(target),
		.comp_high(comp_high));

	// Clock and hang guard
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			err_count++;
			end_of_test();
		end
	end

	// Random source and expected code
	function automatic logic [RES_BITS-1:0] next_rand(input logic [RES_BITS-1:0] s);
		return {s[RES_BITS-2:0], s[17] ^ s[10]};
	endfunction : next_rand
	function automatic logic [RES_BITS-1:0] exp_code(input logic [RES_BITS-1:0] t,
		input logic ov, input logic un);
		return ov ? CODE_MAX : (un ? CODE_MIN : t);
	endfunction : exp_code

	// One conversion, with an early refused edge and trigger noise while busy
	task automatic convert(input logic [RES_BITS-1:0] t, input logic ov, input logic un);
		int n;
		n = 0;
		trig = 1'b0;
		@(negedge clk);
		trig = 1'b1;
		repeat (3) @(negedge clk);
		`CHK("early start", 1'b0, busy)
		trig = 1'b0;
		target = t;
		over_range = ov;
		under_range = un;
		repeat (10) @(negedge clk);
		trig = 1'b1;
		while (busy !== 1'b1 && n < 3) begin
			@(negedge clk);
			n++;
		end
		`CHK("busy", 1'b1, busy)
		`CHK("switches", 3'b001, sw_ctl)
		`CHK("held result", exp_q, result)
		trig = 1'b0;
		repeat (4) @(negedge clk);
		trig = 1'b1;
		n = 0;
		while (done_pulse !== 1'b1 && n < 80) begin
			@(negedge clk);
			n++;
		end
		exp_q = exp_code(t, ov, un);
		`CHK("done", 1'b1, done_pulse)
		`CHK("busy end", 1'b0, busy)
		`CHK("result", exp_q, result)
		`CHK("trial code", t ^ MSB_ONLY, trial_code)
	endtask : convert

	// Verdict
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : end_of_test

	// Main sequence: corner codes, range clamps, then random codes
	initial begin
		reset = 1'b1;
		trig = 1'b0;
		target = CODE_ZERO;
		over_range = 1'b0;
		under_range = 1'b0;
		exp_q = CODE_ZERO;
		lfsr_q = 18'h00026;
		repeat (16) @(negedge clk);
		`CHK("reset busy", 1'b0, busy)
		`CHK("reset switches", 3'b111, sw_ctl)
		`CHK("reset result", CODE_ZERO, result)
		reset = 1'b0;
		for (int i = 0; i < 8; i++) begin
			convert(corner[i], i == 6, i == 7);
			$display("corner test %0d done", i);
		end
		for (int i = 0; i < 8; i++) begin
			lfsr_q = next_rand(lfsr_q);
			convert(lfsr_q, lfsr_q[0] & lfsr_q[1], lfsr_q[2] & lfsr_q[3]);
			$display("random test %0d done", i);
		end
		end_of_test();
	end
endmodule : sar_conversion_sequencer_test
`default_nettype wire
